/* hw/eeprom_map.svh */
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH
// Overview of operation
// - write-all stores one word everywhere at once
// - write-all lasts one ordinary program cycle
// - power-up leaves writes disabled
// - write-protect command disables writes again
// - disabled: writes ignored, reads still work
// - select low during frame aborts write
// - started program cycle completes unless reset
// - select rising with clock high samples data
// - select low drops partial input
// - select high makes device active
// - power-on reset forces write protect
// - low supply discards pending write
// - dummy zero out on last address bit
// - busy/ready shown while select high
// - fifth pulse after ready takes start bit
// - sample on clock rise, shift out too
// - first one after select is start
// - output off when deselected; low busy
// - program starts on select fall only

// geometry
`define ADDR_BITS 6
`define DATA_BITS 16

// opcodes and extended-command selectors (top two address bits)
`define OPC_READ   2'h2
`define OPC_WRITE  2'h1
`define OPC_ERASE  2'h3
`define OPC_EXT    2'h0
`define EXT_WEN    2'h3
`define EXT_WDS    2'h0
`define EXT_WRITE_ALL_WORDS_CMD   2'h1
`define EXT_ERAL   2'h2

// timing
`define CLK_MHZ      25
`define PROG_TIME_US 10000
`define PROG_CYCLES  (`PROG_TIME_US * `CLK_MHZ)
`define READY_GRACE  3'h4
`endif

/* hw/eeprom_pkg.sv */
package eeprom_pkg;

    // pins from the host, sampled together
    typedef struct packed {
        logic cs;
        logic sck;
        logic din;
        logic supply_low;
    } pins_t;

    // data-out pin: level and active-low enable
    typedef struct packed {
        logic level;
        logic oe_n;
    } dout_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_OPC    = 3'h1,
        ST_ADDR   = 3'h3,
        ST_DATA   = 3'h2,
        ST_DONE   = 3'h6,
        ST_READ   = 3'h7,
        ST_STATUS = 3'h5
    } state_t;

    typedef enum logic [2:0] {
        CMD_READ, CMD_WRITE, CMD_ERASE, CMD_WEN,
        CMD_WDS, CMD_WRITE_ALL_WORDS_CMD, CMD_ERAL
    } cmd_t;

    typedef enum logic [1:0] {
        JOB_NONE, JOB_WORD, JOB_ALL
    } job_t;

endpackage

/* hw/serial_eeprom_write_control.sv */
`timescale 1ns/1ns
`include "eeprom_map.svh"

module serial_eeprom_write_control
#(
    parameter int unsigned ADDR_W      = `ADDR_BITS,
    parameter int unsigned DATA_W      = `DATA_BITS,
    parameter int unsigned PROG_CYCLES = `PROG_CYCLES
)
(
    input  wire logic          clk,
    input  wire logic          resetn,
    input  eeprom_pkg::pins_t  pins,
    output eeprom_pkg::dout_t  dout
);
    import eeprom_pkg::*;

    localparam int CNT_W = $clog2(DATA_W) + 1;
    localparam int PW    = $clog2(PROG_CYCLES + 1);
    localparam int WORDS = 1 << ADDR_W;

    generate
        if (ADDR_W < 3 || ADDR_W > DATA_W || PROG_CYCLES < 1)
        begin : g_bad
            $error("unsupported geometry or program time");
        end
    endgenerate

    // **********************************************************
    // command decode
    // **********************************************************
    function automatic cmd_t decode(input logic [1:0] opc,
                                    input logic [1:0] sel);
        cmd_t c;
        c = CMD_READ;
        if (opc == `OPC_WRITE)
            c = CMD_WRITE;
        else if (opc == `OPC_ERASE)
            c = CMD_ERASE;
        else if (opc == `OPC_EXT)
        begin
            if (sel == `EXT_WEN)
                c = CMD_WEN;
            else if (sel == `EXT_WDS)
                c = CMD_WDS;
            else if (sel == `EXT_WRITE_ALL_WORDS_CMD)
                c = CMD_WRITE_ALL_WORDS_CMD;
            else
                c = CMD_ERAL;
        end
        return c;
    endfunction

    // **********************************************************
    // reset release and pin synchronisers
    // **********************************************************
    logic  rst_meta_reg;
    logic  rst_n;
    pins_t sync1_reg;
    pins_t sync2_reg;
    pins_t prev_reg;

    // reset asserts at once but leaves on our clock
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // two flops, then a third copy only for edge finding
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= '0;
        end
        else
        begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    wire cs      = sync2_reg.cs;
    wire sck     = sync2_reg.sck;
    wire din     = sync2_reg.din;
    wire low     = sync2_reg.supply_low;
    wire cs_rise = cs & ~prev_reg.cs;
    wire cs_fall = ~cs & prev_reg.cs;
    // select rising onto a high clock counts as a clock rise
    wire sk_rise = cs & ((sck & ~prev_reg.sck)
                         | (cs_rise & sck));

    // **********************************************************
    // state and storage
    // **********************************************************
    state_t              state_reg, state_next;
    logic [CNT_W-1:0]    cnt_reg, cnt_next;
    logic [1:0]          opc_reg, opc_next;
    logic [ADDR_W-1:0]   addr_reg, addr_next;
    logic [DATA_W-1:0]   shift_reg, shift_next;
    job_t                job_reg, job_next;
    logic                wen_reg, wen_next;
    logic                armed_reg, armed_next;
    logic                busy_reg;
    logic [PW-1:0]       prog_cnt_reg;
    logic [2:0]          ready_cnt_reg;
    dout_t               dout_reg, dout_next;
    logic [DATA_W-1:0]   mem [WORDS];

    wire [ADDR_W-1:0] addr_in  = {addr_reg[ADDR_W-2:0], din};
    wire [DATA_W-1:0] data_in  = {shift_reg[DATA_W-2:0], din};
    wire cmd_t        cmd      = decode(opc_reg,
                                        addr_in[ADDR_W-1 -: 2]);
    wire addr_last = cnt_reg == CNT_W'(ADDR_W - 1);
    wire data_last = cnt_reg == CNT_W'(DATA_W - 1);
    wire prog_done = busy_reg && prog_cnt_reg == '0;
    // waiting for ready plus four grace pulses
    wire grace_over = !busy_reg
                      && ready_cnt_reg == `READY_GRACE;
    // programming begins only once the frame is closed
    wire start_prog = cs_fall && state_reg == ST_DONE
                      && job_reg != JOB_NONE
                      && !low && !busy_reg;

    // **********************************************************
    // frame sequencer
    // **********************************************************
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        opc_next   = opc_reg;
        addr_next  = addr_reg;
        shift_next = shift_reg;
        job_next   = job_reg;
        wen_next   = wen_reg;
        armed_next = armed_reg;
        dout_next  = dout_reg;
        if (prog_done)
            job_next = JOB_NONE;
        if (!cs)
        begin
            // deselect throws away any unfinished frame
            cnt_next       = '0;
            dout_next.oe_n = 1'b1;
            if (start_prog)
                armed_next = 1'b1;
            else if (!busy_reg)
                job_next = JOB_NONE;
            state_next = (start_prog || armed_reg)
                         ? ST_STATUS : ST_IDLE;
        end
        else if (low && state_reg != ST_READ
                 && state_reg != ST_STATUS)
        begin
            if (!busy_reg)
                job_next = JOB_NONE;
            state_next = ST_DONE;
        end
        else
        begin
            if (state_reg == ST_STATUS)
            begin
                dout_next.oe_n  = 1'b0;
                dout_next.level = ~busy_reg;
            end
            else if (state_reg != ST_READ)
                dout_next.oe_n = 1'b1;
            if (sk_rise)
            begin
                unique case (state_reg)
                    ST_IDLE:
                        if (din && !busy_reg)
                        begin
                            state_next = ST_OPC;
                            cnt_next   = '0;
                        end
                    ST_STATUS:
                        if (grace_over && din)
                        begin
                            state_next     = ST_OPC;
                            cnt_next       = '0;
                            armed_next     = 1'b0;
                            dout_next.oe_n = 1'b1;
                        end
                    ST_OPC:
                    begin
                        opc_next = {opc_reg[0], din};
                        cnt_next = cnt_reg + 1'b1;
                        if (cnt_reg[0])
                        begin
                            state_next = ST_ADDR;
                            cnt_next   = '0;
                        end
                    end
                    ST_ADDR:
                    begin
                        addr_next = addr_in;
                        cnt_next  = cnt_reg + 1'b1;
                        if (addr_last)
                        begin
                            cnt_next   = '0;
                            state_next = ST_DONE;
                            unique case (cmd)
                                CMD_READ:
                                begin
                                    state_next      = ST_READ;
                                    shift_next      = mem[addr_in];
                                    dout_next.oe_n  = 1'b0;
                                    dout_next.level = 1'b0;
                                end
                                CMD_WRITE, CMD_WRITE_ALL_WORDS_CMD:
                                    if (wen_reg)
                                        state_next = ST_DATA;
                                CMD_ERASE, CMD_ERAL:
                                    if (wen_reg)
                                    begin
                                        shift_next = '1;
                                        job_next = (cmd == CMD_ERAL)
                                                   ? JOB_ALL
                                                   : JOB_WORD;
                                    end
                                CMD_WEN:
                                    wen_next = 1'b1;
                                CMD_WDS:
                                    wen_next = 1'b0;
                            endcase
                        end
                    end
                    ST_DATA:
                    begin
                        shift_next = data_in;
                        cnt_next   = cnt_reg + 1'b1;
                        if (data_last)
                        begin
                            state_next = ST_DONE;
                            cnt_next   = '0;
                            job_next   = (opc_reg == `OPC_EXT)
                                         ? JOB_ALL
                                         : JOB_WORD;
                        end
                    end
                    ST_DONE:
                        state_next = ST_DONE;
                    ST_READ:
                    begin
                        // shift out on rises, then step to next word
                        dout_next.level = shift_reg[DATA_W-1];
                        shift_next = {shift_reg[DATA_W-2:0], 1'b0};
                        cnt_next   = cnt_reg + 1'b1;
                        if (data_last)
                        begin
                            cnt_next   = '0;
                            addr_next  = addr_reg + 1'b1;
                            shift_next = mem[addr_reg + 1'b1];
                        end
                    end
                    default:
                        state_next = ST_IDLE;
                endcase
            end
        end
    end

    // **********************************************************
    // registers
    // **********************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
            opc_reg   <= '0;
            addr_reg  <= '0;
            shift_reg <= '0;
            job_reg   <= JOB_NONE;
            wen_reg   <= 1'b0;
            armed_reg <= 1'b0;
            dout_reg  <= '{level: 1'b0, oe_n: 1'b1};
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            opc_reg   <= opc_next;
            addr_reg  <= addr_next;
            shift_reg <= shift_next;
            job_reg   <= job_next;
            wen_reg   <= wen_next;
            armed_reg <= armed_next;
            dout_reg  <= dout_next;
        end
    end

    assign dout = dout_reg;

    // program timer: nothing but reset stops it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_reg     <= 1'b0;
            prog_cnt_reg <= '0;
        end
        else if (start_prog)
        begin
            busy_reg     <= 1'b1;
            prog_cnt_reg <= PW'(PROG_CYCLES - 1);
        end
        else if (busy_reg)
        begin
            busy_reg     <= !prog_done;
            prog_cnt_reg <= prog_cnt_reg - 1'b1;
        end
    end

    // pulses seen since ready came up, capped at the grace
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ready_cnt_reg <= '0;
        else if (state_reg != ST_STATUS || busy_reg || !cs)
            ready_cnt_reg <= '0;
        else if (sk_rise && !grace_over)
            ready_cnt_reg <= ready_cnt_reg + 1'b1;
    end

    // array commits at the end of the cycle; one word, or the whole array at once for write-all and erase-all
    always_ff @(posedge clk)
    begin
        if (prog_done && job_reg == JOB_ALL)
        begin
            for (int i = 0; i < WORDS; i++)
                mem[i] <= shift_reg;
        end
        else if (prog_done && job_reg == JOB_WORD)
            mem[addr_reg] <= shift_reg;
    end

endmodule

/* dv/eeprom_port_monitor.sv */
`timescale 1ns/1ns
module eeprom_port_monitor
#(
    parameter int unsigned PROG_CYCLES = 250000
)
(
    input wire logic         clk,
    input wire logic         resetn,
    input eeprom_pkg::pins_t pins,
    input eeprom_pkg::dout_t dout
);
    import eeprom_pkg::*;
    // ****************************************
    // port checks
    // ****************************************
    int   sck_age_reg;
    int   fall_age_reg;
    logic status_reg;
    logic seen_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // ages since clock rise and select fall; status means driven, no clocking
    // a select that showed status does not restart the program age, so a
    // late poll that finds ready is not taken for a fresh busy period
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sck_age_reg  <= 100;
            fall_age_reg <= 0;
            status_reg   <= 1'b0;
            seen_reg     <= 1'b0;
        end
        else
        begin
            sck_age_reg  <= $rose(pins.sck) ? 0
                          : sck_age_reg + int'(sck_age_reg < 100);
            fall_age_reg <= ($fell(pins.cs) && !seen_reg) ? 0
                          : fall_age_reg
                            + int'(fall_age_reg < PROG_CYCLES + 99);
            seen_reg     <= $rose(pins.cs) ? 1'b0 : seen_reg || status_reg;
            status_reg   <= !dout.oe_n && (status_reg
                          || ($fell(dout.oe_n) && sck_age_reg > 8));
        end
    end

    deselect_off_a: assert property ($fell(pins.cs) |-> ##[1:6] dout.oe_n)
        else $error("output still driven after deselect");
    stays_off_a: assert property (!pins.cs [*6] |-> dout.oe_n)
        else $error("output driven while deselected");
    drive_select_a: assert property ($fell(dout.oe_n) |->
        $past(pins.cs, 2) && $past(pins.cs, 3))
        else $error("output driven without select");
    dummy_zero_a: assert property ($fell(dout.oe_n) && sck_age_reg <= 8
        |-> !dout.level)
        else $error("dummy bit not zero");
    fall_clocked_a: assert property ($fell(dout.level) && !dout.oe_n
        && !$past(dout.oe_n) |-> sck_age_reg <= 8)
        else $error("read data moved without clock");
    read_steady_a: assert property (!dout.oe_n && !$past(dout.oe_n)
        && !status_reg && sck_age_reg > 8 |-> $stable(dout.level))
        else $error("read data unstable");
    busy_low_a: assert property (status_reg
        && fall_age_reg < PROG_CYCLES |-> !dout.level)
        else $error("ready shown too early");
    ready_time_a: assert property (status_reg
        && fall_age_reg == PROG_CYCLES + 12 |-> dout.level)
        else $error("ready not shown in time");

    cover property (status_reg && $rose(dout.level));
    cover property ($fell(dout.oe_n) && sck_age_reg <= 8);
    cover property ($fell(pins.cs) && status_reg);
endmodule

bind serial_eeprom_write_control eeprom_port_monitor
    #(.PROG_CYCLES(PROG_CYCLES)) mon
    (.clk(clk), .resetn(resetn), .pins(pins), .dout(dout));

/* dv/serial_host.sv */
`timescale 1ns/1ns
module serial_host
(
    input  wire logic        clk,
    output eeprom_pkg::pins_t pins,
    input  eeprom_pkg::dout_t dout
);
    import eeprom_pkg::*;
    // ****************************************
    // host side of the three-wire port
    // ****************************************
    // everything low at rest so no false start appears
    initial pins = '0;

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one 320 ns clock pulse; output sampled late in the low phase
    task automatic pulse(input logic d, output logic q);
        pins.din = d;
        step(2);
        pins.sck = 1'b1;
        step(4);
        pins.sck = 1'b0;
        step(2);
        q = dout.oe_n ? 1'bx : dout.level;
    endtask

    // 25 bits msb first; leading zeros ahead of the start are harmless
    task automatic send(input logic [24:0] v, output logic q);
        for (int i = 24; i >= 0; i--)
            pulse(v[i], q);
        pins.din = 1'b0;
    endtask

    // select up or down, then give the synchronisers time to follow
    task automatic cs_on();
        pins.cs = 1'b1;
        step(4);
    endtask

    task automatic cs_off();
        pins.cs = 1'b0;
        step(4);
    endtask

    // supply lockout level up or down
    task automatic lockout_on();
        pins.supply_low = 1'b1;
        step(2);
    endtask

    task automatic lockout_off();
        pins.supply_low = 1'b0;
        step(2);
    endtask

    // select raised while the clock is already high, data high
    task automatic early_start();
        pins.sck = 1'b1;
        pins.din = 1'b1;
        step(2);
        pins.cs = 1'b1;
        step(4);
        pins.sck = 1'b0;
        pins.din = 1'b0;
        step(2);
    endtask
endmodule

/* dv/serial_eeprom_write_control_test.sv */
`timescale 1ns/1ns
`include "eeprom_map.svh"
module serial_eeprom_write_control_test;
    import eeprom_pkg::*;
    // ****************************************
    // bench for the serial write control
    // ****************************************
    localparam int unsigned PROG = 50;  // short program cycle for sim
    localparam logic [8:0]  WEN  = {1'b1, `OPC_EXT, `EXT_WEN, 4'h0};
    localparam logic [8:0]  WRITE_PROTECT_CMD  = {1'b1, `OPC_EXT, `EXT_WDS, 4'h0};
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    pins_t       pins;
    dout_t       dout;
    int          err_total = 0;
    int          checks = 0;
    logic        q;
    logic [15:0] w;

    always #20 clk = ~clk;

    serial_host host (.clk(clk), .pins(pins), .dout(dout));
    serial_eeprom_write_control #(.PROG_CYCLES(PROG)) dut
    (
        .clk    (clk),
        .resetn (resetn),
        .pins   (pins),
        .dout   (dout)
    );

    // comparison and reporting
    task automatic check_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic check_word(input string nm, input logic [15:0] e,
                              input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // frame helpers
    function automatic logic [24:0] write_all_words_cmd(input logic [15:0] d);
        return {1'b1, `OPC_EXT, `EXT_WRITE_ALL_WORDS_CMD, 4'h0, d};
    endfunction
    // let n rising edges pass, then step just off the last one
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [24:0] v);
        host.cs_on();
        host.send(v, q);
        host.cs_off();
    endtask
    task automatic no_status(input string nm);
        host.cs_on();
        hold(2);
        check_bit(nm, 1'b1, dout.oe_n);
        host.cs_off();
    endtask
    task automatic read_tail(output logic [15:0] d);
        check_bit("dummy bit", 1'b0, q);
        for (int i = 15; i >= 0; i--)
            host.pulse(1'b0, d[i]);
        host.cs_off();
    endtask
    task automatic read_chk(input logic [5:0] a, input logic [15:0] e);
        host.cs_on();
        host.send({16'h0, 1'b1, `OPC_READ, a}, q);
        read_tail(w);
        check_word("read word", e, w);
    endtask
    task automatic wait_ready();
        int n = 0;
        while (dout.level !== 1'b1 && n < 4 * PROG)
        begin
            hold(1);
            n++;
        end
        check_bit("ready time", 1'b1, n >= PROG - 16 && n <= PROG);
    endtask

    // scenarios
    task automatic t_write_all();
        cmd(write_all_words_cmd(16'h1234));
        no_status("status while protected");
        cmd({16'h0, WEN});
        cmd(write_all_words_cmd(16'ha5c3));
        host.cs_on();
        hold(2);
        check_bit("busy level", 1'b0, dout.level);
        check_bit("busy drive", 1'b0, dout.oe_n);
        wait_ready();
        host.cs_off();
        hold(2);
        check_bit("released", 1'b1, dout.oe_n);
        read_chk(6'h00, 16'ha5c3);
        read_chk(6'h3f, 16'ha5c3);
    endtask
    task automatic t_cancel();
        cmd({8'h0, 1'b1, `OPC_WRITE, 6'h03, 8'h00});
        no_status("status after abort");
        read_chk(6'h03, 16'ha5c3);
        host.lockout_on();
        cmd({1'b1, `OPC_WRITE, 6'h07, 16'h0000});
        host.lockout_off();
        no_status("status under lockout");
        read_chk(6'h07, 16'ha5c3);
    endtask
    task automatic t_fifth_pulse();
        cmd({1'b1, `OPC_WRITE, 6'h09, 16'h3c5a});
        host.cs_on();
        wait_ready();
        repeat (4) host.pulse(1'b1, q);
        check_bit("ready held", 1'b1, q);
        for (int i = 8; i >= 0; i--)
            host.pulse(WRITE_PROTECT_CMD[i], q);
        host.cs_off();
        cmd(write_all_words_cmd(16'h0000));
        no_status("status after protect");
        read_chk(6'h09, 16'h3c5a);
    endtask
    task automatic t_early_start();
        logic [7:0] v;
        v = {`OPC_READ, 6'h09};
        host.early_start();
        for (int i = 7; i >= 0; i--)
            host.pulse(v[i], q);
        read_tail(w);
        check_word("early start read", 16'h3c5a, w);
    endtask
    task automatic t_reset();
        cmd({16'h0, WEN});
        resetn = 1'b0;
        hold(8);
        resetn = 1'b1;
        hold(4);
        cmd(write_all_words_cmd(16'h0000));
        no_status("status after reset");
        read_chk(6'h00, 16'ha5c3);
    endtask

    // main sequence: reset held 8 clocks, then the scenarios
    initial
    begin
        repeat (8) @(posedge clk);
        #1 resetn = 1'b1;
        hold(4);
        t_write_all();
        t_cancel();
        t_fifth_pulse();
        t_early_start();
        t_reset();
        conclude();
    end

    // run needs under 5k clocks; allow ten times that
    initial
    begin
        #2000000;
        err_total++;
        $display("unexpected run length expected finish seen timeout");
        conclude();
    end
endmodule
